// >>> core/ptu_top.sv
// time counter, timing message processing and event pin of the time unit
// Functional notes
// R1 - software reads and writes a time counter with 2^-32 ns fraction.
// R2 - only the low 32 seconds bits exist; the top 16 are not kept.
// R3 - event messages run one-step (stamp inserted) or two-step by config.
// R4 - between ports the unit acts as an end-to-end or peer-to-peer TC.
// R5 - the host port acts as a master or slave ordinary clock.
// R6 - ingress stamps, egress stamps, residence and link delay into correction.
// R7 - turn-around time and egress stamps may be inserted on the way out.
// R8 - a changed IPv4 UDP frame gets its checksum recomputed or zeroed.
// R9 - a changed IPv6 UDP frame always gets its checksum recomputed.
// R10 - processing only with protocol and detection enabled, then by mode.
// R11 - timing frames over IPv4, IPv6 or raw Ethernet, multicast or unicast.
// R12 - timing frames the host does not need are dropped before it.
// R13 - trigger waveform on the event pin when the target time is reached.
// R14 - an edge on the event pin latches the time counter.
// R15 - trigger and capture each raise a maskable interrupt.
// R16 - software keeps all copper ports at 100 Mbps while timing is used.
// R17 - the counter adds a programmable increment each clock; delays adjust.
`timescale 1ns/1ps
`include "ptu_cfg.svh"

module ptu_top #(
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rd_data,
  input wire logic ing_sof,
  output ptu_pkg::ptu_time_t ing_ts,
  input wire logic msg_valid,
  input wire ptu_pkg::ptu_msg_in_t msg_in,
  output logic out_valid,
  output ptu_pkg::ptu_msg_out_t msg_out,
  input wire logic evt_in,
  output logic evt_out,
  output logic evt_oe,
  output logic irq
);
  import ptu_pkg::*;

  initial begin
    if (TW < 1 || TW > 16) begin
      $error("ptu_top: TW must lie in 1..16");
    end
  end

  // register state
  logic [`PTU_CTRL_W-1:0] ctrl_r;
  logic [7:0] dom_r;
  logic [7:0] inc_ns_r;
  logic [31:0] inc_frac_r;
  ptu_time_t load_r;
  ptu_time_t snap_r;
  logic [31:0] snap_frac_r;
  ptu_time_t trig_r;
  logic [TW-1:0] trig_wid_r;
  ptu_time_t cap_r;
  logic [29:0] rx_dly_r;
  logic [29:0] tx_dly_r;
  logic [15:0] link_dly_r;
  logic [`PTU_INT_W-1:0] stat_r;
  logic [`PTU_INT_W-1:0] mask_r;
  logic [31:0] rd_data_r;
  // counter state
  ptu_time_t stc_r;
  logic [31:0] frac_r;
  // trigger, capture, interrupt, ingress stamp and message answer state
  logic armed_r;
  logic [TW-1:0] trig_cnt_r;
  logic evt_out_r;
  logic evt_oe_r;
  logic evt_prev_r;
  logic irq_r;
  ptu_time_t ing_ts_r;
  logic out_valid_r;
  ptu_msg_out_t msg_out_r;

  logic wr_ctrl;
  logic trig_hit;
  logic cap_edge;
  logic [`PTU_INT_W-1:0] stat_set;
  ptu_msg_out_t msg_nxt;

  // add a nanosecond offset, carrying into seconds
  function automatic ptu_time_t t_add(input ptu_time_t t,
                                      input logic [29:0] d);
    ptu_time_t r;
    logic [30:0] n;
    r = t;
    n = {1'b0, t.ns} + {1'b0, d};
    if (n >= {1'b0, `PTU_NS_PER_SEC}) begin
      n = n - {1'b0, `PTU_NS_PER_SEC};
      r.sec = t.sec + 32'h1;
    end
    r.ns = n[29:0];
    return r;
  endfunction

  // subtract a nanosecond offset, borrowing from seconds
  function automatic ptu_time_t t_sub(input ptu_time_t t,
                                      input logic [29:0] d);
    ptu_time_t r;
    r = t;
    if (t.ns >= d) begin
      r.ns = t.ns - d;
    end else begin
      r.ns = t.ns + `PTU_NS_PER_SEC - d;
      r.sec = t.sec - 32'h1;
    end
    return r;
  endfunction

  // nanoseconds from b to a, assumed under one second
  function automatic logic [29:0] t_diff(input ptu_time_t a,
                                         input ptu_time_t b);
    logic [29:0] r;
    if (a.ns >= b.ns) begin
      r = a.ns - b.ns;
    end else begin
      r = a.ns + `PTU_NS_PER_SEC - b.ns;
    end
    return r;
  endfunction

  // incremental one's complement fix for a changed 64-bit field
  function automatic logic [15:0] csum_adj(input logic [15:0] hc,
                                           input logic [63:0] o,
                                           input logic [63:0] n);
    logic [31:0] s;
    s = {16'h0, ~hc};
    for (int i = 0; i < 4; i++) begin
      s = s + {16'h0, ~o[i*16 +: 16]} + {16'h0, n[i*16 +: 16]};
    end
    s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
    s = {16'h0, s[15:0]} + {16'h0, s[31:16]};
    return ~s[15:0];
  endfunction

  assign wr_ctrl = wr_en && (addr == `PTU_OFS_CTRL);

  // control and configuration registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrl_r <= '0;
      dom_r <= 8'h00;
      inc_ns_r <= `PTU_RST_INC_NS;
      inc_frac_r <= `PTU_RST_INC_FRAC;
      load_r <= '0;
      trig_r <= '0;
      trig_wid_r <= TW'(`PTU_RST_TRIG_WID);
      rx_dly_r <= 30'h0;
      tx_dly_r <= 30'h0;
      link_dly_r <= 16'h0;
      mask_r <= '0;
    end else if (wr_en) begin
      unique case (addr)
        `PTU_OFS_CTRL: ctrl_r <= wr_data[`PTU_CTRL_W-1:0];
        `PTU_OFS_DOMAIN: dom_r <= wr_data[7:0];
        `PTU_OFS_INC_NS: inc_ns_r <= wr_data[7:0];
        `PTU_OFS_INC_FRAC: inc_frac_r <= wr_data;
        `PTU_OFS_LOAD_SEC: load_r.sec <= wr_data;
        `PTU_OFS_LOAD_NS: load_r.ns <= wr_data[29:0];
        `PTU_OFS_TRIG_SEC: trig_r.sec <= wr_data;
        `PTU_OFS_TRIG_NS: trig_r.ns <= wr_data[29:0];
        `PTU_OFS_TRIG_WID: trig_wid_r <= wr_data[TW-1:0];
        `PTU_OFS_RX_DLY: rx_dly_r <= wr_data[29:0];
        `PTU_OFS_TX_DLY: tx_dly_r <= wr_data[29:0];
        `PTU_OFS_LINK_DLY: link_dly_r <= wr_data[15:0];
        `PTU_OFS_INT_MASK: mask_r <= wr_data[`PTU_INT_W-1:0];
        default: ;
      endcase
    end
  end

  // time counter: load on command, else advance every clock
  always_ff @(posedge clk or negedge arst_n) begin
    logic [32:0] f;
    ptu_time_t t;
    if (!arst_n) begin
      stc_r <= '0;
      frac_r <= 32'h0;
    end else begin
      f = {1'b0, frac_r} + {1'b0, inc_frac_r};
      t = t_add(stc_r, {22'h0, inc_ns_r} + {29'h0, f[32]});
      // R1 - load and tick
      if (wr_ctrl && wr_data[`PTU_CTRL_LOAD]) begin
        stc_r <= load_r;
        frac_r <= 32'h0;
      end else begin
        // R17 - programmable increment
        stc_r <= t;
        frac_r <= f[31:0];
      end
    end
  end

  // snapshot for software reads of the running counter
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      snap_r <= '0;
      snap_frac_r <= 32'h0;
    end else if (wr_ctrl && wr_data[`PTU_CTRL_SNAP]) begin
      // R2 - low seconds only
      snap_r <= stc_r;
      snap_frac_r <= frac_r;
    end
  end

  // target reached once the counter is at or past it
  assign trig_hit = armed_r && ((stc_r.sec > trig_r.sec) ||
                    (stc_r.sec == trig_r.sec && stc_r.ns >= trig_r.ns));

  // trigger arm, match and output pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      armed_r <= 1'b0;
      trig_cnt_r <= '0;
      evt_out_r <= 1'b0;
    end else begin
      if (wr_ctrl && wr_data[`PTU_CTRL_ARM]) begin
        armed_r <= wr_data[`PTU_CTRL_TRIG_EN];
      end else if (trig_hit || !ctrl_r[`PTU_CTRL_TRIG_EN]) begin
        armed_r <= 1'b0;
      end
      // R13 - pulse on match
      if (trig_hit && ctrl_r[`PTU_CTRL_TRIG_EN]) begin
        trig_cnt_r <= trig_wid_r;
        evt_out_r <= 1'b1;
      end else if (trig_cnt_r > TW'(1)) begin
        trig_cnt_r <= trig_cnt_r - TW'(1);
      end else begin
        trig_cnt_r <= '0;
        evt_out_r <= 1'b0;
      end
    end
  end

  // pin drives while trigger output is enabled
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      evt_oe_r <= 1'b0;
      evt_prev_r <= 1'b0;
    end else begin
      evt_oe_r <= ctrl_r[`PTU_CTRL_TRIG_EN];
      evt_prev_r <= evt_in;
    end
  end

  // capture edge, rising or falling by config, only when not driving
  assign cap_edge = ctrl_r[`PTU_CTRL_CAP_EN] && !evt_oe_r &&
                    (ctrl_r[`PTU_CTRL_CAP_FALL] ? (evt_prev_r && !evt_in)
                                                : (!evt_prev_r && evt_in));

  // input timestamp latch
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cap_r <= '0;
    end else if (cap_edge) begin
      // R14 - latch counter
      cap_r <= stc_r;
    end
  end

  // R15 - events into status
  assign stat_set = {cap_edge && stat_r[`PTU_INT_CAP], cap_edge,
                     trig_hit && ctrl_r[`PTU_CTRL_TRIG_EN]};

  // sticky status, write one clears, a new event wins over the clear
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stat_r <= '0;
    end else if (wr_en && addr == `PTU_OFS_INT_STAT) begin
      stat_r <= (stat_r & ~wr_data[`PTU_INT_W-1:0]) | stat_set;
    end else begin
      stat_r <= stat_r | stat_set;
    end
  end

  // R15 - masked interrupt level
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(stat_r & mask_r);
    end
  end

  // read data one cycle after the strobe, held between strobes, zero for unmapped offsets
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_data_r <= 32'h0;
    end else if (rd_en) begin
      unique case (addr)
        `PTU_OFS_CTRL: rd_data_r <= {19'h0, armed_r, 2'b00, ctrl_r};
        `PTU_OFS_DOMAIN: rd_data_r <= {24'h0, dom_r};
        `PTU_OFS_INC_NS: rd_data_r <= {24'h0, inc_ns_r};
        `PTU_OFS_INC_FRAC: rd_data_r <= inc_frac_r;
        `PTU_OFS_LOAD_SEC: rd_data_r <= load_r.sec;
        `PTU_OFS_LOAD_NS: rd_data_r <= {2'b00, load_r.ns};
        `PTU_OFS_SNAP_SEC: rd_data_r <= snap_r.sec;
        `PTU_OFS_SNAP_NS: rd_data_r <= {2'b00, snap_r.ns};
        `PTU_OFS_SNAP_FRAC: rd_data_r <= snap_frac_r;
        `PTU_OFS_TRIG_SEC: rd_data_r <= trig_r.sec;
        `PTU_OFS_TRIG_NS: rd_data_r <= {2'b00, trig_r.ns};
        `PTU_OFS_TRIG_WID: rd_data_r <= 32'(trig_wid_r);
        `PTU_OFS_CAP_SEC: rd_data_r <= cap_r.sec;
        `PTU_OFS_CAP_NS: rd_data_r <= {2'b00, cap_r.ns};
        `PTU_OFS_RX_DLY: rd_data_r <= {2'b00, rx_dly_r};
        `PTU_OFS_TX_DLY: rd_data_r <= {2'b00, tx_dly_r};
        `PTU_OFS_LINK_DLY: rd_data_r <= {16'h0, link_dly_r};
        `PTU_OFS_INT_STAT: rd_data_r <= {29'h0, stat_r};
        `PTU_OFS_INT_MASK: rd_data_r <= {29'h0, mask_r};
        default: rd_data_r <= 32'h0;
      endcase
    end
  end

  // ingress stamp, backed off by the receive delay
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ing_ts_r <= '0;
    end else if (ing_sof) begin
      // R6 - ingress stamp
      ing_ts_r <= t_sub(stc_r, rx_dly_r);
    end
  end

  // message decision for one frame at egress
  always_comb begin
    ptu_time_t eg;
    logic [29:0] res;
    logic need;
    logic evnt;
    logic tc;
    eg = t_add(stc_r, tx_dly_r);
    res = t_diff(eg, msg_in.ing_ts);
    evnt = msg_in.msg_type < `PTU_MSG_FOLLOW;
    tc = !msg_in.to_host && !msg_in.from_host;
    msg_nxt = '0;
    msg_nxt.corr = msg_in.corr;
    msg_nxt.csum = msg_in.csum;
    // R6 - egress stamp recorded
    msg_nxt.ts = eg;
    // R12 - what the host port wants
    need = msg_in.msg_type == `PTU_MSG_PD_REQ ||
           msg_in.msg_type == `PTU_MSG_PD_RESP ||
           msg_in.msg_type == `PTU_MSG_PD_FUP ||
           msg_in.msg_type > `PTU_MSG_ANNOUNCE;
    // R5 - master or slave needs
    if (ctrl_r[`PTU_CTRL_MASTER]) begin
      need = need || msg_in.msg_type == `PTU_MSG_DLY_REQ;
    end else begin
      need = need || msg_in.msg_type == `PTU_MSG_SYNC ||
             msg_in.msg_type == `PTU_MSG_FOLLOW ||
             msg_in.msg_type == `PTU_MSG_DLY_RESP ||
             msg_in.msg_type == `PTU_MSG_ANNOUNCE;
    end
    // R10 - gate and mode select
    // R11 - recognised transports
    if (ctrl_r[`PTU_CTRL_PTP_EN] && ctrl_r[`PTU_CTRL_DET_EN] &&
        msg_in.xport != PTU_XP_NONE) begin
      if (ctrl_r[`PTU_CTRL_DOM_CHK] && msg_in.domain != dom_r) begin
        msg_nxt.drop = msg_in.to_host;
      end else if (msg_in.to_host && !need) begin
        // R12 - filter for host
        msg_nxt.drop = 1'b1;
      end else if (msg_in.to_host) begin
        msg_nxt.ts = msg_in.ing_ts;
      end else if (evnt && tc) begin
        // R4 - peer delay stays on the link
        if (ctrl_r[`PTU_CTRL_P2P] && msg_in.mcast &&
            (msg_in.msg_type == `PTU_MSG_PD_REQ ||
             msg_in.msg_type == `PTU_MSG_PD_RESP)) begin
          msg_nxt.drop = 1'b1;
        end else begin
          // R6 - residence and link delay
          msg_nxt.modified = 1'b1;
          msg_nxt.corr = msg_in.corr + {18'h0, res, 16'h0};
          if (ctrl_r[`PTU_CTRL_P2P] &&
              msg_in.msg_type == `PTU_MSG_SYNC) begin
            msg_nxt.corr = msg_nxt.corr + {32'h0, link_dly_r, 16'h0};
          end
        end
      end else if (evnt && ctrl_r[`PTU_CTRL_ONE_STEP]) begin
        // R3 - one-step from the host port
        if (msg_in.msg_type == `PTU_MSG_SYNC &&
            ctrl_r[`PTU_CTRL_MASTER]) begin
          // R7 - egress stamp insertion
          msg_nxt.ins_ts = 1'b1;
          msg_nxt.modified = 1'b1;
          msg_nxt.csum = csum_adj(msg_in.csum,
                                  {msg_in.orig_sec, msg_in.orig_ns},
                                  {eg.sec, 2'b00, eg.ns});
        end else if (msg_in.msg_type == `PTU_MSG_PD_RESP) begin
          // R7 - turn-around time
          msg_nxt.modified = 1'b1;
          msg_nxt.corr = msg_in.corr + {18'h0, res, 16'h0};
        end
      end
      if (msg_nxt.modified && !msg_nxt.drop) begin
        msg_nxt.csum = csum_adj(msg_nxt.csum, msg_in.corr, msg_nxt.corr);
        if (msg_in.xport == PTU_XP_IPV4) begin
          // R8 - recompute or zero
          msg_nxt.csum_mode = ctrl_r[`PTU_CTRL_V4_ZERO] ? PTU_CS_ZERO
                                                         : PTU_CS_UPDATE;
          if (ctrl_r[`PTU_CTRL_V4_ZERO]) begin
            msg_nxt.csum = 16'h0;
          end
        end else if (msg_in.xport == PTU_XP_IPV6) begin
          // R9 - always recompute
          msg_nxt.csum_mode = PTU_CS_UPDATE;
        end else begin
          msg_nxt.csum = msg_in.csum;
        end
      end
    end
  end

  // registered message answer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_valid_r <= 1'b0;
      msg_out_r <= '0;
    end else begin
      out_valid_r <= msg_valid;
      if (msg_valid) begin
        msg_out_r <= msg_nxt;
      end
    end
  end

  assign rd_data = rd_data_r;
  assign ing_ts = ing_ts_r;
  assign out_valid = out_valid_r;
  assign msg_out = msg_out_r;
  assign evt_out = evt_out_r;
  assign evt_oe = evt_oe_r;
  assign irq = irq_r;

endmodule

// >>> core/ptu_cfg.svh
// register offsets, field positions, reset values and counts of the time unit
`ifndef PTU_CFG_SVH
`define PTU_CFG_SVH

`define PTU_OFS_CTRL      8'h00
`define PTU_OFS_DOMAIN    8'h04
`define PTU_OFS_INC_NS    8'h08
`define PTU_OFS_INC_FRAC  8'h0c
`define PTU_OFS_LOAD_SEC  8'h10
`define PTU_OFS_LOAD_NS   8'h14
`define PTU_OFS_SNAP_SEC  8'h18
`define PTU_OFS_SNAP_NS   8'h1c
`define PTU_OFS_SNAP_FRAC 8'h20
`define PTU_OFS_TRIG_SEC  8'h24
`define PTU_OFS_TRIG_NS   8'h28
`define PTU_OFS_TRIG_WID  8'h2c
`define PTU_OFS_CAP_SEC   8'h30
`define PTU_OFS_CAP_NS    8'h34
`define PTU_OFS_RX_DLY    8'h38
`define PTU_OFS_TX_DLY    8'h3c
`define PTU_OFS_LINK_DLY  8'h40
`define PTU_OFS_INT_STAT  8'h44
`define PTU_OFS_INT_MASK  8'h48

`define PTU_CTRL_PTP_EN   0
`define PTU_CTRL_DET_EN   1
`define PTU_CTRL_ONE_STEP 2
`define PTU_CTRL_P2P      3
`define PTU_CTRL_MASTER   4
`define PTU_CTRL_DOM_CHK  5
`define PTU_CTRL_V4_ZERO  6
`define PTU_CTRL_TRIG_EN  7
`define PTU_CTRL_CAP_EN   8
`define PTU_CTRL_CAP_FALL 9
`define PTU_CTRL_LOAD     10
`define PTU_CTRL_SNAP     11
`define PTU_CTRL_ARM      12
`define PTU_CTRL_W        10

`define PTU_INT_TRIG      0
`define PTU_INT_CAP       1
`define PTU_INT_CAP_OVR   2
`define PTU_INT_W         3

`define PTU_RST_INC_NS    8'h0a
`define PTU_RST_INC_FRAC  32'h0000_0000
`define PTU_RST_TRIG_WID  16'h000a
`define PTU_NS_PER_SEC    30'h3b9a_ca00

`define PTU_MSG_SYNC      4'h0
`define PTU_MSG_DLY_REQ   4'h1
`define PTU_MSG_PD_REQ    4'h2
`define PTU_MSG_PD_RESP   4'h3
`define PTU_MSG_FOLLOW    4'h8
`define PTU_MSG_DLY_RESP  4'h9
`define PTU_MSG_PD_FUP    4'ha
`define PTU_MSG_ANNOUNCE  4'hb

`endif

// >>> core/ptu_pkg.sv
// types shared by the time and timestamp unit
package ptu_pkg;

  typedef struct packed {
    logic [31:0] sec;
    logic [29:0] ns;
  } ptu_time_t;

  typedef enum logic [1:0] {
    PTU_XP_NONE,
    PTU_XP_ETH,
    PTU_XP_IPV4,
    PTU_XP_IPV6
  } ptu_xport_t;

  typedef enum logic [1:0] {
    PTU_CS_KEEP,
    PTU_CS_UPDATE,
    PTU_CS_ZERO
  } ptu_csum_t;

  typedef struct packed {
    ptu_xport_t xport;
    logic mcast;
    logic [3:0] msg_type;
    logic [7:0] domain;
    logic to_host;
    logic from_host;
    logic [63:0] corr;
    logic [31:0] orig_sec;
    logic [31:0] orig_ns;
    ptu_time_t ing_ts;
    logic [15:0] csum;
  } ptu_msg_in_t;

  typedef struct packed {
    logic drop;
    logic modified;
    logic ins_ts;
    logic [63:0] corr;
    ptu_time_t ts;
    ptu_csum_t csum_mode;
    logic [15:0] csum;
  } ptu_msg_out_t;

endpackage

// >>> tb/ptu_top_properties.sv
// port assertions of the time unit
`timescale 1ns/1ps
`include "ptu_cfg.svh"
module ptu_top_properties #(
  parameter int TW = 16
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [31:0] wr_data,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [31:0] rd_data,
  input wire logic ing_sof,
  input wire ptu_pkg::ptu_time_t ing_ts,
  input wire logic msg_valid,
  input wire ptu_pkg::ptu_msg_in_t msg_in,
  input wire logic out_valid,
  input wire ptu_pkg::ptu_msg_out_t msg_out,
  input wire logic evt_in,
  input wire logic evt_out,
  input wire logic evt_oe,
  input wire logic irq
);
  import ptu_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // domain write followed by its read back
  sequence s_dom_wr; wr_en && addr == `PTU_OFS_DOMAIN; endsequence
  sequence s_dom_rd; rd_en && addr == `PTU_OFS_DOMAIN; endsequence
  property p_dom;
    s_dom_wr ##2 s_dom_rd |=> rd_data[7:0] == $past(wr_data[7:0], 3);
  endproperty
  property p_ans; msg_valid |=> out_valid; endproperty
  property p_idle; !msg_valid |=> !out_valid && $stable(msg_out); endproperty
  property p_sof; !ing_sof |=> $stable(ing_ts); endproperty
  property p_unmap; rd_en && addr == 8'h4c |=> rd_data == 32'h0; endproperty
  property p_off;
    msg_valid && msg_in.xport == PTU_XP_NONE |=>
      !msg_out.modified && !msg_out.drop;
  endproperty
  property p_v6;
    msg_valid && msg_in.xport == PTU_XP_IPV6 |=>
      !msg_out.modified || msg_out.csum_mode == PTU_CS_UPDATE;
  endproperty
  property p_eth;
    msg_valid && msg_in.xport == PTU_XP_ETH |=>
      !msg_out.modified || msg_out.csum_mode == PTU_CS_KEEP;
  endproperty
  property p_oe; evt_out |-> evt_oe; endproperty
  a_dom: assert property (p_dom)
    else $error("domain readback wrong");
  a_ans: assert property (p_ans)
    else $error("message answer missing");
  a_idle: assert property (p_idle)
    else $error("message answer without request");
  a_sof: assert property (p_sof)
    else $error("ingress stamp moved without frame start");
  a_unmap: assert property (p_unmap)
    else $error("unmapped read not zero");
  a_off: assert property (p_off)
    else $error("non timing frame touched");
  a_v6: assert property (p_v6)
    else $error("ipv6 checksum not updated");
  a_eth: assert property (p_eth)
    else $error("ethernet frame checksum touched");
  a_oe: assert property (p_oe)
    else $error("trigger without output enable");
endmodule
bind ptu_top ptu_top_properties #(.TW(TW)) u_props (
  .clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
  .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ing_sof(ing_sof),
  .ing_ts(ing_ts), .msg_valid(msg_valid), .msg_in(msg_in),
  .out_valid(out_valid), .msg_out(msg_out), .evt_in(evt_in),
  .evt_out(evt_out), .evt_oe(evt_oe), .irq(irq));

// >>> tb/ptu_evt_src.sv
// external event source on the shared event pin
`timescale 1ns/1ps
module ptu_evt_src (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic go,
  input wire logic dev_oe,
  input wire logic dev_out,
  output logic pin
);
  logic lvl_r;
  // one edge on the pin for each request
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      lvl_r <= 1'b0;
    end else if (go) begin
      lvl_r <= ~lvl_r;
    end
  end
  // the unit owns the line while its output is enabled
  assign pin = dev_oe ? dev_out : lvl_r;
endmodule

// >>> tb/test_ptp_time_and_timestamp_unit.sv
// self-checking bench of the time and timestamp unit
`timescale 1ns/1ps
`include "ptu_cfg.svh"
module test_ptp_time_and_timestamp_unit;
  import ptu_pkg::*;
  logic clk = 0, arst_n = 0, wr_en = 0, rd_en = 0, ing_sof = 0;
  logic [7:0] addr = '0, dom;
  logic [31:0] wr_data = '0, rd_data, ctrl_v, ld_sec, v, r, rxd, txd, lnk;
  logic [29:0] ld_ns;
  logic [63:0] s1, s2, inc;
  logic msg_valid = 0, go = 0, out_valid, evt_in, evt_out, evt_oe, irq;
  ptu_time_t ing_ts, its;
  ptu_msg_in_t msg_in = '0, m;
  ptu_msg_out_t msg_out;
  integer err_total = 0, checked = 0, seed = 32'h3939, n;
  int tl[8] = '{0, 1, 2, 3, 8, 9, 11, 12};
  logic [31:0] cl[6] = '{32'h0, 32'h1, 32'h3, 32'h4b, 32'h17, 32'h3b};

  always #5 clk = ~clk;

  ptu_top dut (.clk(clk), .arst_n(arst_n), .addr(addr), .wr_data(wr_data),
    .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .ing_sof(ing_sof),
    .ing_ts(ing_ts), .msg_valid(msg_valid), .msg_in(msg_in),
    .out_valid(out_valid), .msg_out(msg_out), .evt_in(evt_in),
    .evt_out(evt_out), .evt_oe(evt_oe), .irq(irq));
  ptu_evt_src src (.clk(clk), .arst_n(arst_n), .go(go), .dev_oe(evt_oe),
    .dev_out(evt_out), .pin(evt_in));

  task report_and_stop();
    if (err_total == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task chk(input string nm, input logic [63:0] seen, input logic [63:0] e);
    checked++;
    if (seen !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, e, seen);
    end
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  task rd(input logic [7:0] a, output logic [31:0] q);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    q = rd_data;
  endtask

  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a, r);
    chk($sformatf("reg %h", a), {32'h0, r}, {32'h0, e});
  endtask

  task cnt_hi(output integer k);
    k = 0;
    repeat (20) begin
      @(posedge clk);
      #1;
      if (evt_out === 1'b1) k++;
    end
  endtask

  task evt();
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  // expected decision for one descriptor with the counter held still
  function automatic ptu_msg_out_t model(ptu_msg_in_t q);
    ptu_msg_out_t o;
    logic [29:0] eg;
    logic nd;
    eg = ld_ns + txd[29:0];
    o = '0;
    o.corr = q.corr;
    o.ts = {ld_sec, eg};
    nd = q.msg_type inside {2, 3, 10} || q.msg_type > 11 ||
      (ctrl_v[4] ? q.msg_type == 1 : q.msg_type inside {0, 8, 9, 11});
    if (!(ctrl_v[0] && ctrl_v[1]) || q.xport == PTU_XP_NONE) return o;
    if (ctrl_v[5] && q.domain != dom) o.drop = q.to_host;
    else if (q.to_host) begin
      o.drop = !nd;
      o.ts = q.ing_ts;
    end else if (!q.from_host && q.msg_type < 8) begin
      if (ctrl_v[3] && q.mcast && q.msg_type inside {2, 3}) begin
        o.drop = 1'b1;
      end else begin
        o.modified = 1'b1;
        o.corr = q.corr + (64'(eg - q.ing_ts.ns) << 16);
        if (ctrl_v[3] && q.msg_type == 0) o.corr += 64'(lnk[15:0]) << 16;
      end
    end else if (q.from_host && ctrl_v[2] && q.msg_type inside {0, 3}) begin
      o.modified = ctrl_v[4] || q.msg_type == 3;
      o.ins_ts = o.modified && q.msg_type == 0;
      if (q.msg_type == 3) o.corr = q.corr + (64'(eg - q.ing_ts.ns) << 16);
    end
    if (o.modified) o.csum_mode = q.xport == PTU_XP_ETH ? PTU_CS_KEEP :
      (q.xport == PTU_XP_IPV4 && ctrl_v[6]) ? PTU_CS_ZERO : PTU_CS_UPDATE;
    return o;
  endfunction

  task sendm(input ptu_msg_in_t q);
    ptu_msg_out_t e;
    e = model(q);
    @(posedge clk);
    msg_valid <= 1'b1;
    msg_in <= q;
    @(posedge clk);
    msg_valid <= 1'b0;
    #1;
    chk("out_valid", 64'(out_valid), 64'h1);
    chk("drop", 64'(msg_out.drop), 64'(e.drop));
    chk("modified", 64'(msg_out.modified), 64'(e.modified));
    chk("ins_ts", 64'(msg_out.ins_ts), 64'(e.ins_ts));
    chk("corr", msg_out.corr, e.corr);
    if (ctrl_v[1:0] == 2'b11 && q.xport != PTU_XP_NONE && !e.drop)
      chk("ts", 64'(msg_out.ts), 64'(e.ts));
    if (e.modified) chk("csum", 64'(msg_out.csum_mode), 64'(e.csum_mode));
  endtask

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end

  // main sequence; links assumed at 100 Mbps
  initial begin
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    rdc(`PTU_OFS_INC_NS, 32'h0a);
    rdc(`PTU_OFS_INC_FRAC, 32'h0);
    rdc(`PTU_OFS_TRIG_WID, 32'h0a);
    rdc(8'h4c, 32'h0);
    v = $random(seed);
    dom = v[7:0];
    wr(`PTU_OFS_DOMAIN, {24'h0, dom});
    rdc(`PTU_OFS_DOMAIN, {24'h0, dom});
    // two snapshots a hundred cycles apart
    v = $random(seed);
    inc = {32'h3, v};
    wr(`PTU_OFS_INC_NS, 32'h3);
    wr(`PTU_OFS_INC_FRAC, v);
    wr(`PTU_OFS_LOAD_SEC, 32'h0);
    wr(`PTU_OFS_LOAD_NS, 32'h0);
    wr(`PTU_OFS_CTRL, 32'h400);
    wr(`PTU_OFS_CTRL, 32'h800);
    rd(`PTU_OFS_SNAP_NS, s1[63:32]);
    rd(`PTU_OFS_SNAP_FRAC, s1[31:0]);
    repeat (94) @(posedge clk);
    wr(`PTU_OFS_CTRL, 32'h800);
    rd(`PTU_OFS_SNAP_NS, s2[63:32]);
    rd(`PTU_OFS_SNAP_FRAC, s2[31:0]);
    chk("step", s2 - s1, inc * 100);
    // counter frozen at a random time
    v = $random(seed);
    ld_sec = $random(seed);
    ld_ns = 30'(v[15:0]) + 30'd1000;
    rxd = {24'h0, v[23:16]};
    txd = {24'h0, v[31:24]};
    lnk = {16'h0, v[15:0]};
    wr(`PTU_OFS_INC_NS, 32'h0);
    wr(`PTU_OFS_INC_FRAC, 32'h0);
    wr(`PTU_OFS_LOAD_SEC, ld_sec);
    wr(`PTU_OFS_LOAD_NS, {2'b0, ld_ns});
    wr(`PTU_OFS_CTRL, 32'h400);
    wr(`PTU_OFS_CTRL, 32'h800);
    rdc(`PTU_OFS_SNAP_SEC, ld_sec);
    rdc(`PTU_OFS_SNAP_NS, {2'b0, ld_ns});
    rdc(`PTU_OFS_SNAP_FRAC, 32'h0);
    wr(`PTU_OFS_RX_DLY, rxd);
    wr(`PTU_OFS_TX_DLY, txd);
    wr(`PTU_OFS_LINK_DLY, lnk);
    its = {ld_sec, ld_ns - rxd[29:0]};
    @(posedge clk);
    ing_sof <= 1'b1;
    @(posedge clk);
    ing_sof <= 1'b0;
    #1;
    chk("ing_ts", 64'(ing_ts), 64'(its));
    // six control settings, every transport, eight message types and every direction
    foreach (cl[c]) begin
      ctrl_v = cl[c];
      wr(`PTU_OFS_CTRL, ctrl_v);
      for (int x = 0; x < 4; x++) begin
        for (int t = 0; t < 8; t++) begin
          for (int d = 0; d < 3; d++) begin
            r = $random(seed);
            m = '0;
            m.xport = ptu_xport_t'(x);
            m.mcast = r[0];
            m.domain = r[1] ? dom : dom + 8'h1;
            m.msg_type = 4'(tl[t]);
            m.to_host = d == 1;
            m.from_host = d == 2;
            m.corr = {16'h0, r, 16'h0};
            m.ing_ts = its;
            m.csum = r[31:16];
            sendm(m);
          end
        end
      end
    end
    // trigger output and its interrupt
    wr(`PTU_OFS_TRIG_WID, 32'h3);
    wr(`PTU_OFS_TRIG_SEC, ld_sec);
    wr(`PTU_OFS_TRIG_NS, {2'b0, ld_ns + 30'd5});
    wr(`PTU_OFS_CTRL, 32'h1080);
    cnt_hi(n);
    chk("early", 64'(n), 64'h0);
    rdc(`PTU_OFS_CTRL, 32'h1080);
    wr(`PTU_OFS_TRIG_NS, {2'b0, ld_ns});
    cnt_hi(n);
    chk("width", 64'(n), 64'h3);
    chk("oe", 64'(evt_oe), 64'h1);
    rdc(`PTU_OFS_INT_STAT, 32'h1);
    chk("irq", 64'(irq), 64'h0);
    wr(`PTU_OFS_INT_MASK, 32'h3);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 64'(irq), 64'h1);
    wr(`PTU_OFS_INT_STAT, 32'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("irq", 64'(irq), 64'h0);
    // capture from the event pin
    wr(`PTU_OFS_CTRL, 32'h100);
    evt();
    rdc(`PTU_OFS_CAP_SEC, ld_sec);
    rdc(`PTU_OFS_CAP_NS, {2'b0, ld_ns});
    rdc(`PTU_OFS_INT_STAT, 32'h2);
    chk("irq", 64'(irq), 64'h1);
    evt();
    evt();
    rdc(`PTU_OFS_INT_STAT, 32'h6);
    wr(`PTU_OFS_INT_STAT, 32'h7);
    rdc(`PTU_OFS_INT_STAT, 32'h0);
    wr(`PTU_OFS_CTRL, 32'h300);
    evt();
    rdc(`PTU_OFS_INT_STAT, 32'h2);
    report_and_stop();
  end
endmodule
